// *** bench/atc_conv_model.sv ***
// converter core model: fixed latency, result valid only in the done cycle
module atc_conv_model #(
  parameter int CONV_CYC = 20
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // control side
  input  wire logic        i_power,
  input  wire logic        i_start,
  input  wire logic [11:0] i_value,
  output logic             o_done,
  output logic [11:0]      o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt_ff;
  logic [11:0] hold_ff;
  // a start while unpowered is lost, as on the real core
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff  <= 0;
      o_done  <= 1'b0;
      hold_ff <= 12'h000;
    end else begin
      o_done <= (cnt_ff == 1);
      if (i_start && i_power && cnt_ff == 0) begin
        cnt_ff  <= CONV_CYC;
        hold_ff <= i_value;
      end else if (cnt_ff != 0) begin
        cnt_ff <= cnt_ff - 1;
      end
    end
  end
  // outside the done cycle the bus shows junk, never the last result
  assign o_result = o_done ? hold_ff : ~hold_ff;
endmodule : atc_conv_model

// *** bench/atc_ctrl_tb.sv ***
// self-checking bench for the converter trigger and compare control
module atc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY    = 258;
  localparam int DLY_LO = DLY * int'(atc_pkg::ADC_CLK_DIV);
  logic                  clk;
  logic                  nrst;
  logic                  bwr;
  logic                  brd;
  logic [7:0]            addr;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic [4:0]            sv;
  logic [1:0]            pv;
  logic                  power;
  logic                  start;
  logic                  done;
  logic [11:0]           value;
  logic [11:0]           result;
  atc_pkg::atc_pwm_ctl_t pwm;
  int                    fail_count;
  int                    checks;
  int                    starts;
  int                    n;
  logic [7:0]            ra [10] = '{8'he1, 8'he2, 8'he3, 8'he8, 8'hf0,
                                     8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'h10};
  logic [11:0]           cres [5] = '{12'h800, 12'h7ff, 12'h7ff, 12'h800, 12'hfff};
  logic [7:0]            ccfg [5] = '{8'h20, 8'h20, 8'h60, 8'h60, 8'h00};
  logic [4:0]            cexp = 5'h05;

  atc_ctrl dut (
    .i_ref_clk        (clk),
    .i_nrst           (nrst),
    .i_addr           (addr),
    .i_wdata          (wdata),
    .i_wr             (bwr),
    .i_rd             (brd),
    .o_rdata          (rdata),
    .i_ext_start_pin0 (sv[3]),
    .i_ext_start_pin1 (sv[4]),
    .i_pwm_ch0        (sv[0]),
    .i_pwm_ch2        (sv[1]),
    .i_pwm_ch4        (sv[2]),
    .i_pwm_centre     (pv[0]),
    .i_pwm_end        (pv[1]),
    .o_conv_power     (power),
    .o_conv_start     (start),
    .i_conv_done      (done),
    .i_conv_result    (result),
    .o_pwm            (pwm)
  );
  atc_conv_model mdl (
    .i_clk    (clk),
    .i_nrst   (nrst),
    .i_power  (power),
    .i_start  (start),
    .i_value  (value),
    .o_done   (done),
    .o_result (result)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // counted mid-cycle, where the registered pulse has settled
  always @(negedge clk) begin
    if (start === 1'b1) starts++;
  end

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] e);
    checks++;
    if (seen !== e) begin
      fail_count++;
      $display("ERROR %s exp %h seen %h", nm, e, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    bwr   <= 1'b1;
    @(posedge clk);
    bwr <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    brd  <= 1'b1;
    @(posedge clk);
    brd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {4'h0, rdata}, {4'h0, e});
  endtask : rchk

  // bounded wait on the start pulse or the core's done pulse
  task automatic wait_hi(input logic dn, input int lim, output int m);
    m = 0;
    #1;
    while ((dn ? done : start) !== 1'b1 && m < lim) begin
      @(posedge clk);
      #1;
      m++;
    end
    if ((dn ? done : start) !== 1'b1) begin
      fail_count++;
      $display("ERROR wait %0d exp 1 seen 0", dn);
      finish_test();
    end
  endtask : wait_hi

  task automatic conv(input logic [11:0] v);
    int m;
    @(posedge clk);
    value <= v;
    wr(8'he8, 8'h40);
    wait_hi(1'b0, 4, m);
    wait_hi(1'b1, 40, m);
    wr(8'he8, 8'h00);
  endtask : conv

  // sel 0 toggles every source but the chosen one, sel 1 toggles every source; for PWM pulses sel 0 pulses the other one, sel 1 the chosen one
  task automatic kick(input int i, input logic idle, input logic sel);
    @(posedge clk);
    if (i < 5) sv <= sel ? {5{~idle}} : ({5{~idle}} ^ (5'h01 << i));
    else pv <= sel ? (2'h1 << (i - 5)) : (2'h2 >> (i - 5));
    @(posedge clk);
    pv <= 2'h0;
  endtask : kick

  task automatic ext_case(input int i, input int lim, output int m);
    logic [2:0] ib;
    logic [1:0] typ;
    logic [1:0] src;
    logic       idle;
    int         s0;
    int         q;
    ib   = i[2:0];
    typ  = (i < 5) ? {1'b0, ib[0]} : 2'(ib - 3'h3);
    src  = (i < 3) ? ib[1:0] : (i < 5) ? 2'h3 : 2'h0;
    idle = (i < 5) ? ~typ[0] : 1'b0;
    wr(8'he1, 8'h01);
    wr(8'he8, {2'h0, src, 4'h0});
    @(posedge clk);
    sv <= {5{idle}};
    wr(8'he1, {1'h0, (i == 4), 2'h0, typ, 2'h3});
    s0 = starts;
    kick(i, idle, 1'b0);
    repeat (12) @(posedge clk);
    chk("unselected", 12'(starts - s0), 12'h0);
    kick(i, idle, 1'b1);
    wait_hi(1'b0, lim, m);
    @(posedge clk);
    sv <= {5{idle}};
    kick(i, idle, 1'b1);
    wait_hi(1'b1, 60, q);
    chk("one start", 12'(starts - s0), 12'h1);
    wr(8'he8, {2'h0, src, 4'h0});
  endtask : ext_case

  initial begin
    nrst       = 1'b0;
    bwr        = 1'b0;
    brd        = 1'b0;
    addr       = 8'h00;
    wdata      = 8'h00;
    sv         = 5'h00;
    pv         = 2'h0;
    value      = 12'h000;
    fail_count = 0;
    checks     = 0;
    starts     = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[k]) rchk(ra[k], 8'h00);
    chk("power", 12'(power), 12'h0);
    wr(8'he1, 8'h01);
    chk("power", 12'(power), 12'h1);
    wr(8'he2, 8'h10);
    rchk(8'he2, 8'h00);
    $display("test regs done");
    @(posedge clk);
    value <= 12'h5a3;
    wr(8'he8, 8'h40);
    wait_hi(1'b0, 4, n);
    rchk(8'he8, 8'h40);
    wait_hi(1'b1, 40, n);
    rchk(8'he8, 8'h80);
    rchk(8'hf2, 8'ha3);
    rchk(8'hf3, 8'h05);
    n = starts;
    wr(8'he8, 8'h40);
    repeat (4) @(posedge clk);
    chk("start while done", 12'(starts - n), 12'h0);
    wr(8'he8, 8'h00);
    rchk(8'he8, 8'h00);
    $display("test software start done");
    wr(8'hf0, 8'h00);
    wr(8'hf1, 8'h08);
    for (int k = 0; k < 5; k++) begin
      wr(8'he2, ccfg[k]);
      conv(cres[k]);
      rchk(8'he2, ccfg[k] | {3'h0, cexp[k], 4'h0});
    end
    $display("test compare done");
    wr(8'hf4, 8'h80);
    wr(8'he2, 8'ha0);
    conv(12'h900);
    chk("brake", 12'(pwm.fault_brake), 12'h1);
    chk("run", 12'(pwm.run), 12'h0);
    conv(12'h100);
    chk("brake kept", 12'(pwm.fault_brake), 12'h1);
    wr(8'hf4, 8'h80);
    chk("run", 12'(pwm.run), 12'h1);
    chk("brake", 12'(pwm.fault_brake), 12'h0);
    wr(8'he2, 8'h80);
    conv(12'h900);
    chk("brake off", 12'(pwm.fault_brake), 12'h0);
    $display("test brake done");
    wr(8'he2, 8'h00);
    n = starts;
    @(posedge clk);
    sv <= 5'h1f;
    pv <= 2'h3;
    @(posedge clk);
    pv <= 2'h0;
    repeat (12) @(posedge clk);
    chk("ext disabled", 12'(starts - n), 12'h0);
    for (int i = 0; i < 7; i++) ext_case(i, 12, n);
    $display("test external triggers done");
    wr(8'he2, 8'h01);
    wr(8'he3, 8'h02);
    rchk(8'he2, 8'h01);
    ext_case(1, 1200, n);
    chk("delay", 12'(n >= DLY_LO - 2 && n <= DLY_LO + 10), 12'h1);
    // software start still works with external triggering enabled
    conv(12'h123);
    rchk(8'hf2, 8'h23);
    $display("test delay done");
    finish_test();
  end
endmodule : atc_ctrl_tb

// *** verilog/atc_ctrl.sv ***
// converter trigger, result compare and fault brake control
module atc_ctrl (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_nrst,
  // register port
  input  wire logic [7:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic [7:0]                o_rdata,
  // trigger sources
  input  wire logic                 i_ext_start_pin0,
  input  wire logic                 i_ext_start_pin1,
  input  wire logic                 i_pwm_ch0,
  input  wire logic                 i_pwm_ch2,
  input  wire logic                 i_pwm_ch4,
  input  wire logic                 i_pwm_centre,
  input  wire logic                 i_pwm_end,
  // converter core
  output logic                      o_conv_power,
  output logic                      o_conv_start,
  input  wire logic                 i_conv_done,
  input  wire logic [11:0]          i_conv_result,
  // pwm generator
  output atc_pkg::atc_pwm_ctl_t     o_pwm
);
  atc_pkg::atc_cfg_t  cfg_ff;
  atc_pkg::atc_state_t state_ff;
  atc_pkg::atc_state_t nxt_state;
  logic [11:0] res_ff;
  logic        cmpo_ff;
  logic        done_ff;
  logic        run_ff;
  logic        brake_ff;
  logic        start_ff;
  logic [7:0]  rdata_ff;
  logic [2:0]  div_ff;
  logic        src_prev_ff;
  logic        pin0_lvl;
  logic        pin1_lvl;
  logic        pin_lvl;
  logic        src_lvl;
  logic        edge_hit;
  logic        trig_hit;
  logic        tick;
  logic        fire;
  logic        wr_trg;
  logic        wr_cmp;
  logic        wr_dly;
  logic        wr_stat;
  logic        wr_thl;
  logic        wr_thh;
  logic        wr_pwm;
  logic        sw_go;
  logic        ext_accept;
  logic        fire_go;
  logic        conv_fin;
  logic        cmp_now;
  logic        brake_set;
  logic        busy;

  assign wr_trg  = i_wr && (i_addr == atc_pkg::ADDR_TRIG_CTRL);
  assign wr_cmp  = i_wr && (i_addr == atc_pkg::ADDR_CMP_CTRL);
  assign wr_dly  = i_wr && (i_addr == atc_pkg::ADDR_DLY_LO);
  assign wr_stat = i_wr && (i_addr == atc_pkg::ADDR_STAT);
  assign wr_thl  = i_wr && (i_addr == atc_pkg::ADDR_THR_LO);
  assign wr_thh  = i_wr && (i_addr == atc_pkg::ADDR_THR_HI);
  assign wr_pwm  = i_wr && (i_addr == atc_pkg::ADDR_PWM_CTRL);
  assign busy    = (state_ff == atc_pkg::ST_BUSY);

  // configuration registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_ff <= '0;
    end else begin
      if (wr_trg) begin
        cfg_ff.swap      <= i_wdata[atc_pkg::TRG_SWAP_BIT]; // R1
        cfg_ff.trig_type <= i_wdata[atc_pkg::TRG_TYPE_LSB +: 2]; // R2
        cfg_ff.ext_en    <= i_wdata[atc_pkg::TRG_EXTEN_BIT];
        cfg_ff.power     <= i_wdata[atc_pkg::TRG_POWER_BIT]; // R7
      end
      if (wr_cmp) begin
        cfg_ff.fb_en   <= i_wdata[atc_pkg::CMP_FBEN_BIT];
        cfg_ff.pol     <= i_wdata[atc_pkg::CMP_POL_BIT];
        cfg_ff.cmp_en  <= i_wdata[atc_pkg::CMP_EN_BIT]; // R12
        cfg_ff.dly[8]  <= i_wdata[atc_pkg::CMP_DLY8_BIT]; // R14
      end
      if (wr_dly) begin
        cfg_ff.dly[7:0] <= i_wdata; // R14
      end
      if (wr_stat) begin
        cfg_ff.src <= i_wdata[atc_pkg::STAT_SRC_LSB +: 2]; // R17
      end
      if (wr_thl) begin
        cfg_ff.thr[7:0] <= i_wdata;
      end
      if (wr_thh) begin
        cfg_ff.thr[11:8] <= i_wdata[3:0];
      end
    end
  end

  assign o_conv_power = cfg_ff.power; // R7

  // both pins synchronised all the time so the swap takes effect at once
  atc_sync3 u_sync_pin0 (
    .i_clk  (i_ref_clk),
    .i_nrst (i_nrst),
    .i_d    (i_ext_start_pin0),
    .o_q    (pin0_lvl)
  );

  atc_sync3 u_sync_pin1 (
    .i_clk  (i_ref_clk),
    .i_nrst (i_nrst),
    .i_d    (i_ext_start_pin1),
    .o_q    (pin1_lvl)
  );

  assign pin_lvl = cfg_ff.swap ? pin1_lvl : pin0_lvl; // R1

  always_comb begin
    case (cfg_ff.src) // R17
      atc_pkg::SRC_PWM0: src_lvl = i_pwm_ch0;
      atc_pkg::SRC_PWM2: src_lvl = i_pwm_ch2;
      atc_pkg::SRC_PWM4: src_lvl = i_pwm_ch4;
      default:           src_lvl = pin_lvl;
    endcase
  end

  // previous sample of the selected source
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_lvl; // R19
    end
  end

  always_comb begin
    case (cfg_ff.trig_type) // R2
      atc_pkg::TYP_FALL:   edge_hit = src_prev_ff && !src_lvl; // R19
      atc_pkg::TYP_RISE:   edge_hit = !src_prev_ff && src_lvl; // R19
      atc_pkg::TYP_CENTRE: edge_hit = i_pwm_centre;
      default:             edge_hit = i_pwm_end;
    endcase
  end

  // R3 is software's: centre and end pulses only come in centre-aligned mode
  assign trig_hit = edge_hit && cfg_ff.ext_en; // R4 R5

  // converter clock enable for the delay
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_ff <= 3'h0;
    end else if (div_ff == atc_pkg::ADC_CLK_DIV - 3'h1) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  assign tick = (div_ff == atc_pkg::ADC_CLK_DIV - 3'h1);

  // busy and done both block new starts
  assign sw_go = wr_stat && i_wdata[atc_pkg::STAT_BUSY_BIT] && !busy && !done_ff; // R16 R18
  assign ext_accept = trig_hit && (state_ff == atc_pkg::ST_IDLE) && !done_ff; // R6 R18
  assign fire_go = fire && cfg_ff.ext_en && (state_ff == atc_pkg::ST_DELAY);
  assign conv_fin = busy && i_conv_done;

  atc_delay u_delay (
    .i_clk   (i_ref_clk),
    .i_nrst  (i_nrst),
    .i_start (ext_accept),
    .i_abort (!cfg_ff.ext_en || sw_go),
    .i_tick  (tick),
    .i_count (cfg_ff.dly),
    .o_fire  (fire)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      atc_pkg::ST_IDLE: begin
        if (sw_go) begin
          nxt_state = atc_pkg::ST_BUSY; // R4 R16
        end else if (ext_accept) begin
          nxt_state = atc_pkg::ST_DELAY; // R15
        end
      end
      atc_pkg::ST_DELAY: begin
        if (sw_go || fire_go) begin
          nxt_state = atc_pkg::ST_BUSY; // R5
        end else if (!cfg_ff.ext_en) begin
          nxt_state = atc_pkg::ST_IDLE;
        end
      end
      atc_pkg::ST_BUSY: begin
        if (i_conv_done) begin
          nxt_state = atc_pkg::ST_IDLE; // R16
        end
      end
      default: nxt_state = atc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= atc_pkg::ST_IDLE;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= sw_go || fire_go;
    end
  end

  assign o_conv_start = start_ff;

  // done flag: a completion beats a software clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_ff <= 1'b0;
    end else if (conv_fin) begin
      done_ff <= 1'b1; // R18
    end else if (wr_stat && !i_wdata[atc_pkg::STAT_DONE_BIT]) begin
      done_ff <= 1'b0; // R18
    end
  end

  assign cmp_now = cfg_ff.pol ? (i_conv_result < cfg_ff.thr) // R11
                              : (i_conv_result >= cfg_ff.thr); // R10

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_ff  <= 12'h000;
      cmpo_ff <= 1'b0;
    end else if (conv_fin) begin
      res_ff  <= i_conv_result;
      cmpo_ff <= cfg_ff.cmp_en && cmp_now; // R12 R13
    end
  end

  // brake wins over a run write in the same cycle
  assign brake_set = cmpo_ff && cfg_ff.fb_en && cfg_ff.cmp_en; // R8 R20

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      brake_ff <= 1'b0;
      run_ff   <= 1'b0;
    end else if (brake_set) begin
      brake_ff <= 1'b1; // R8
      run_ff   <= 1'b0; // R8
    end else if (wr_pwm) begin
      run_ff <= i_wdata[atc_pkg::PWM_RUN_BIT];
      if (i_wdata[atc_pkg::PWM_RUN_BIT]) begin
        brake_ff <= 1'b0; // R9
      end
    end
  end

  // one driver for the whole carrier
  assign o_pwm = '{run: run_ff, fault_brake: brake_ff};

  // read data stand for one cycle only
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= atc_pkg::RST_REG;
    end else if (!i_rd) begin
      rdata_ff <= 8'h00;
    end else begin
      case (i_addr)
        atc_pkg::ADDR_TRIG_CTRL: rdata_ff <= {1'b0, cfg_ff.swap, 2'h0, cfg_ff.trig_type,
                                              cfg_ff.ext_en, cfg_ff.power};
        atc_pkg::ADDR_CMP_CTRL:  rdata_ff <= {cfg_ff.fb_en, cfg_ff.pol, cfg_ff.cmp_en,
                                              cmpo_ff, 3'h0, cfg_ff.dly[8]}; // R13
        atc_pkg::ADDR_DLY_LO:    rdata_ff <= cfg_ff.dly[7:0];
        atc_pkg::ADDR_STAT:      rdata_ff <= {done_ff, busy, cfg_ff.src, 4'h0}; // R16
        atc_pkg::ADDR_THR_LO:    rdata_ff <= cfg_ff.thr[7:0];
        atc_pkg::ADDR_THR_HI:    rdata_ff <= {4'h0, cfg_ff.thr[11:8]};
        atc_pkg::ADDR_RES_LO:    rdata_ff <= res_ff[7:0];
        atc_pkg::ADDR_RES_HI:    rdata_ff <= {4'h0, res_ff[11:8]};
        atc_pkg::ADDR_PWM_CTRL:  rdata_ff <= {run_ff, 7'h00};
        default:                 rdata_ff <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_ff;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_r4_src;
    o_conv_start |-> $past(sw_go) || $past(cfg_ff.ext_en);
  endproperty
  a_r4_src: assert property (p_r4_src) else $error("start without a legal cause"); // R4

  property p_r6_ignore;
    busy && trig_hit && !i_conv_done |=> busy && !o_conv_start;
  endproperty
  a_r6_ignore: assert property (p_r6_ignore) else $error("trigger accepted while busy"); // R6

  property p_r16_start;
    sw_go |=> o_conv_start && busy;
  endproperty
  a_r16_start: assert property (p_r16_start) else $error("software start lost"); // R16

  property p_r18_block;
    done_ff && !busy && !(wr_stat && !i_wdata[atc_pkg::STAT_DONE_BIT]) |=> !o_conv_start;
  endproperty
  a_r18_block: assert property (p_r18_block) else $error("start while done flag set"); // R18

  property p_r8_brake;
    cmpo_ff && cfg_ff.fb_en && cfg_ff.cmp_en |=> o_pwm.fault_brake && !o_pwm.run;
  endproperty
  a_r8_brake: assert property (p_r8_brake) else $error("brake not applied"); // R8

  property p_r9_hold;
    o_pwm.fault_brake && !wr_pwm |=> o_pwm.fault_brake;
  endproperty
  a_r9_hold: assert property (p_r9_hold) else $error("brake released without run"); // R9

  property p_r10_cmp;
    conv_fin && cfg_ff.cmp_en && !cfg_ff.pol |=> cmpo_ff == ($past(i_conv_result) >= cfg_ff.thr);
  endproperty
  a_r10_cmp: assert property (p_r10_cmp) else $error("compare ge wrong"); // R10

  property p_r11_cmp;
    conv_fin && cfg_ff.cmp_en && cfg_ff.pol |=> cmpo_ff == ($past(i_conv_result) < cfg_ff.thr);
  endproperty
  a_r11_cmp: assert property (p_r11_cmp) else $error("compare lt wrong"); // R11

  property p_r13_upd;
    $changed(cmpo_ff) |-> $past(conv_fin);
  endproperty
  a_r13_upd: assert property (p_r13_upd) else $error("compare result moved"); // R13

  property p_r20_gate;
    $rose(o_pwm.fault_brake) |-> $past(cfg_ff.cmp_en);
  endproperty
  a_r20_gate: assert property (p_r20_gate) else $error("brake from disabled comparator"); // R20

  property p_r19_once;
    edge_hit && (cfg_ff.trig_type[1] == 1'b0) |=> !edge_hit || $changed(cfg_ff);
  endproperty
  a_r19_once: assert property (p_r19_once) else $error("edge counted twice"); // R19
endmodule : atc_ctrl

// *** verilog/atc_delay.sv ***
// external trigger delay counter in converter clocks
module atc_delay (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // control
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic       i_tick,
  input  wire logic [8:0] i_count,
  // expiry pulse
  output logic            o_fire
);
  logic       busy_ff;
  logic [8:0] cnt_ff;
  logic       fire_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 9'h000;
      fire_ff <= 1'b0;
    end else begin
      fire_ff <= 1'b0;
      if (i_abort) begin
        busy_ff <= 1'b0;
      end else if (i_start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= i_count;
      end else if (busy_ff) begin
        if (cnt_ff == 9'h000) begin
          busy_ff <= 1'b0;
          fire_ff <= 1'b1; // R15
        end else if (i_tick) begin
          cnt_ff <= cnt_ff - 9'h001; // R15
        end
      end
    end
  end

  assign o_fire = fire_ff;

  property p_r15_wait;
    @(posedge i_clk) disable iff (!i_nrst)
      i_start && !i_abort && (i_count != 9'h000) |=> !o_fire [*2];
  endproperty
  a_r15_wait: assert property (p_r15_wait) else $error("delay expired too early"); // R15
endmodule : atc_delay

// *** verilog/atc_pkg.sv ***
// constants and types for the converter trigger and compare control
// Summary of operation
// R1: swap bit picks which of two pins feeds the external start input, at once.
// R2: trigger type picks falling edge, rising edge, PWM centre or PWM end.
// R3: software uses centre or end types only with centre-aligned PWM.
// R4: external trigger disabled means only a software start write converts.
// R5: external trigger enabled means software start or selected external condition.
// R6: external triggers are ignored while a conversion is busy.
// R7: power bit switches the converter off or on; resets to zero.
// R8: brake enable and compare result one force brake data and clear run.
// R9: software sets run again to leave brake; outputs stay braked until then.
// R10: polarity clear: result one when conversion result >= threshold.
// R11: polarity set: result one when conversion result < threshold.
// R12: comparator enable bit, bit 5 of compare control, turns comparator on.
// R13: compare result is read-only and updates after each finished conversion.
// R14: bit 0 of compare control is bit 8 of the trigger delay.
// R15: external trigger waits the 9-bit delay in converter clocks first.
// R16: writing one to start/busy starts; reads one while converting; zero ignored.
// R17: source field picks PWM channel 0, 2, 4 or the external start pin.
// R18: done flag set on completion, cleared by software, blocks new starts.
// R19: edges found by comparing clocked samples; one trigger per edge.
// R20: brake only while the comparator is enabled.
package atc_pkg;
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'he1;
  localparam logic [7:0] ADDR_CMP_CTRL  = 8'he2;
  localparam logic [7:0] ADDR_DLY_LO    = 8'he3;
  localparam logic [7:0] ADDR_STAT      = 8'he8;
  localparam logic [7:0] ADDR_THR_LO    = 8'hf0;
  localparam logic [7:0] ADDR_THR_HI    = 8'hf1;
  localparam logic [7:0] ADDR_RES_LO    = 8'hf2;
  localparam logic [7:0] ADDR_RES_HI    = 8'hf3;
  localparam logic [7:0] ADDR_PWM_CTRL  = 8'hf4;
  // trigger control fields
  localparam int TRG_SWAP_BIT  = 6;
  localparam int TRG_TYPE_LSB  = 2;
  localparam int TRG_EXTEN_BIT = 1;
  localparam int TRG_POWER_BIT = 0;
  // compare control fields
  localparam int CMP_FBEN_BIT  = 7;
  localparam int CMP_POL_BIT   = 6;
  localparam int CMP_EN_BIT    = 5;
  localparam int CMP_RES_BIT   = 4;
  localparam int CMP_DLY8_BIT  = 0;
  // status fields
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_BUSY_BIT = 6;
  localparam int STAT_SRC_LSB  = 4;
  localparam int PWM_RUN_BIT   = 7;
  localparam logic [7:0] RST_REG = 8'h00;
  // system clocks per converter clock
  localparam logic [2:0] ADC_CLK_DIV = 3'h4;
  localparam logic [1:0] TYP_FALL   = 2'h0;
  localparam logic [1:0] TYP_RISE   = 2'h1;
  localparam logic [1:0] TYP_CENTRE = 2'h2;
  localparam logic [1:0] TYP_END    = 2'h3;
  localparam logic [1:0] SRC_PWM0 = 2'h0;
  localparam logic [1:0] SRC_PWM2 = 2'h1;
  localparam logic [1:0] SRC_PWM4 = 2'h2;
  localparam logic [1:0] SRC_PIN  = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DELAY = 3'h2,
    ST_BUSY  = 3'h4
  } atc_state_t;
  typedef struct packed {
    logic       swap;
    logic [1:0] trig_type;
    logic       ext_en;
    logic       power;
    logic       fb_en;
    logic       pol;
    logic       cmp_en;
    logic [1:0] src;
    logic [8:0] dly;
    logic [11:0] thr;
  } atc_cfg_t;
  typedef struct packed {
    logic run;
    logic fault_brake;
  } atc_pwm_ctl_t;
endpackage : atc_pkg

// *** verilog/atc_sync3.sv ***
// three-stage pin synchroniser with agreement filter
module atc_sync3 (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // pin and clean level
  input  wire logic i_d,
  output logic      o_q
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign o_q = q_ff;
endmodule : atc_sync3
